/* File: rtl/calendar_time_switch.sv */
/*
 * calendar time switch: weekly three-cam switch and yearly date switch,
 * configured over an AHB-Lite slave, evaluated on each time-source strobe.
 * assumes one AHB master, word accesses, and time inputs stable with the strobe.
 */
// Summary of operation
// - weekly switch has three independent cams
// - shared pulse option: output high until the next strobe
// - set at on-time, clear at off-time
// - overlapping cams: first off-time ends interval
// - output comes from all cams jointly
// - each cam acts only on masked weekdays
// - cam times in hours and minutes
// - unset time gives no switching action
// - yearly dates limited to 2000 through 2099
// - yearly dates act only at midnight; a pulse ends at the next strobe
// - dates ordered year, month, day
// - monthly mode: on-day to off-day each month
// - yearly mode: on-date to off-date, may wrap
// - on year first, off year last year
// - yearly pulse lasts one evaluation cycle
// - no mode set: one single span
// - yearly mode: no restart after final wrapping off
// - single pulse fires once only
`timescale 1ns/100ps
module calendar_time_switch (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic eval_strobe,
    input wire logic [6:0] tod_year,
    input wire logic [3:0] tod_month,
    input wire logic [4:0] tod_day,
    input wire logic [2:0] tod_weekday,
    input wire logic [4:0] tod_hour,
    input wire logic [5:0] tod_minute,
    output logic week_out,
    output logic year_out
);
    typedef struct packed {
        logic [calendar_pkg::CTRL_W-1:0] ctrl;
        logic [calendar_pkg::NUM_CAMS-1:0][31:0] cam;
        logic [31:0] on_date;
        logic [31:0] off_date;
        logic [13:0] stamp;
        logic seen;
        logic week_out;
        logic year_out;
        logic year_done;
        logic w_pend;
        logic [7:0] w_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } state_t;

    state_t s;
    state_t next_s;
    logic [calendar_pkg::NUM_CAMS-1:0] on_hits;
    logic [calendar_pkg::NUM_CAMS-1:0] off_hits;
    logic any_on;
    logic any_off;
    logic year_set;
    logic year_clr;
    logic [13:0] now;
    logic new_min;
    logic day_tick;
    logic take;
    logic week_pulse;
    logic year_pulse;
    logic single_mode;

    for (genvar i = 0; i < calendar_pkg::NUM_CAMS; i++) begin : g_cam
        cam_match u_cam (
            .cam(s.cam[i]),
            .weekday(tod_weekday),
            .hour(tod_hour),
            .minute(tod_minute),
            .on_hit(on_hits[i]),
            .off_hit(off_hits[i])
        );
    end

    year_match u_year (
        .monthly(s.ctrl[calendar_pkg::CTRL_MONTHLY]),
        .yearly(s.ctrl[calendar_pkg::CTRL_YEARLY]),
        .on_date(s.on_date),
        .off_date(s.off_date),
        .year(tod_year),
        .month(tod_month),
        .day(tod_day),
        .set_hit(year_set),
        .clr_hit(year_clr)
    );

    assign any_on = |on_hits;
    assign any_off = |off_hits;
    assign now = {tod_weekday, tod_hour, tod_minute};
    // a minute is acted on at its first strobe only
    assign new_min = eval_strobe && (!s.seen || now != s.stamp);
    assign day_tick = new_min && tod_hour == calendar_pkg::MIDNIGHT_HR &&
                      tod_minute == calendar_pkg::MIDNIGHT_MIN;
    assign take = hsel && hready && htrans[1];
    assign week_pulse = s.ctrl[calendar_pkg::CTRL_WEEK_PULSE];
    assign year_pulse = s.ctrl[calendar_pkg::CTRL_YEAR_PULSE];
    assign single_mode = !s.ctrl[calendar_pkg::CTRL_MONTHLY] &&
                         !s.ctrl[calendar_pkg::CTRL_YEARLY];

    always_comb begin
        next_s = s;
        // data phase of a write: bad times or dates leave the register as it was
        if (s.w_pend) begin
            unique case (s.w_addr)
                calendar_pkg::ADDR_CTRL: begin
                    next_s.ctrl = hwdata[calendar_pkg::CTRL_W-1:0];
                end
                calendar_pkg::ADDR_CAM0: begin
                    if (calendar_pkg::cam_ok(hwdata)) next_s.cam[0] = hwdata;
                end
                calendar_pkg::ADDR_CAM1: begin
                    if (calendar_pkg::cam_ok(hwdata)) next_s.cam[1] = hwdata;
                end
                calendar_pkg::ADDR_CAM2: begin
                    if (calendar_pkg::cam_ok(hwdata)) next_s.cam[2] = hwdata;
                end
                calendar_pkg::ADDR_ON_DATE: begin
                    if (calendar_pkg::date_ok(hwdata)) begin
                        next_s.on_date = hwdata;
                        next_s.year_done = 1'b0;
                    end
                end
                calendar_pkg::ADDR_OFF_DATE: begin
                    if (calendar_pkg::date_ok(hwdata)) next_s.off_date = hwdata;
                end
                default: begin
                end
            endcase
        end
        // weekly switch
        if (eval_strobe) begin
            next_s.seen = 1'b1;
            next_s.stamp = now;
        end
        if (week_pulse) begin
            if (eval_strobe) next_s.week_out = 1'b0;
            if (new_min && any_on) next_s.week_out = 1'b1;
        end else if (new_min) begin
            if (any_on) next_s.week_out = 1'b1;
            else if (any_off) next_s.week_out = 1'b0;
        end
        // yearly switch
        if (year_pulse) begin
            if (eval_strobe) next_s.year_out = 1'b0;
            if (day_tick && year_set && !(single_mode && s.year_done)) begin
                next_s.year_out = 1'b1;
                next_s.year_done = single_mode;
            end
        end else if (day_tick) begin
            if (year_set) next_s.year_out = 1'b1;
            else if (year_clr) next_s.year_out = 1'b0;
        end
        // address phase; register read data built from the updated state, status bits from the current state
        next_s.w_pend = take && hwrite;
        next_s.w_addr = haddr[7:0];
        next_s.hrdata = 32'h0000_0000;
        if (take && !hwrite && haddr[31:8] == 24'h00_0000) begin
            unique case (haddr[7:0])
                calendar_pkg::ADDR_CTRL: next_s.hrdata[calendar_pkg::CTRL_W-1:0] = next_s.ctrl;
                calendar_pkg::ADDR_CAM0: next_s.hrdata = next_s.cam[0];
                calendar_pkg::ADDR_CAM1: next_s.hrdata = next_s.cam[1];
                calendar_pkg::ADDR_CAM2: next_s.hrdata = next_s.cam[2];
                calendar_pkg::ADDR_ON_DATE: next_s.hrdata = next_s.on_date;
                calendar_pkg::ADDR_OFF_DATE: next_s.hrdata = next_s.off_date;
                calendar_pkg::ADDR_STATUS: begin
                    next_s.hrdata[calendar_pkg::STAT_WEEK] = s.week_out;
                    next_s.hrdata[calendar_pkg::STAT_YEAR] = s.year_out;
                    next_s.hrdata[calendar_pkg::STAT_DONE] = s.year_done;
                end
                default: next_s.hrdata = 32'h0000_0000;
            endcase
        end
        if (haddr[31:8] != 24'h00_0000) next_s.w_pend = 1'b0;
        next_s.hreadyout = 1'b1;
        next_s.hresp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s.ctrl <= calendar_pkg::CTRL_RESET;
            s.cam <= {calendar_pkg::NUM_CAMS{calendar_pkg::CAM_RESET}};
            s.on_date <= calendar_pkg::DATE_RESET;
            s.off_date <= calendar_pkg::DATE_RESET;
            s.stamp <= 14'h0000;
            s.seen <= 1'b0;
            s.week_out <= 1'b0;
            s.year_out <= 1'b0;
            s.year_done <= 1'b0;
            s.w_pend <= 1'b0;
            s.w_addr <= 8'h00;
            s.hrdata <= 32'h0000_0000;
            s.hreadyout <= 1'b1;
            s.hresp <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = s.hresp;
    assign week_out = s.week_out;
    assign year_out = s.year_out;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_pulse_high;
        week_pulse && week_out;
    endsequence

    sequence s_pulse_strobe;
        eval_strobe && !(new_min && any_on);
    endsequence

    property p_week_pulse;
        s_pulse_high ##0 s_pulse_strobe |=> !week_out;
    endproperty
    a_week_pulse: assert property (p_week_pulse) else $error("week pulse too long");

    property p_week_set;
        new_min && any_on |=> week_out;
    endproperty
    a_week_set: assert property (p_week_set) else $error("week on missed");

    property p_first_off;
        !week_pulse && new_min && any_off && !any_on |=> !week_out;
    endproperty
    a_first_off: assert property (p_first_off) else $error("off time ignored");

    property p_week_cause;
        $rose(week_out) |-> $past(new_min && any_on);
    endproperty
    a_week_cause: assert property (p_week_cause) else $error("week set without cam");

    property p_once_per_min;
        eval_strobe && s.seen && now == s.stamp |=>
            ($past(week_pulse) ? !week_out : $stable(week_out));
    endproperty
    a_once_per_min: assert property (p_once_per_min) else $error("minute acted twice");

    property p_year_range;
        s.on_date[calendar_pkg::DATE_YEAR_LSB +: 7] <= calendar_pkg::YEAR_MAX &&
        s.off_date[calendar_pkg::DATE_YEAR_LSB +: 7] <= calendar_pkg::YEAR_MAX;
    endproperty
    a_year_range: assert property (p_year_range) else $error("year out of range");

    property p_year_midnight;
        !year_pulse && $changed(year_out) && !$past(s.w_pend) |->
            $past(day_tick);
    endproperty
    a_year_midnight: assert property (p_year_midnight) else $error("year edge not at midnight");

    property p_year_pulse;
        year_pulse && year_out && eval_strobe && !day_tick |=> !year_out;
    endproperty
    a_year_pulse: assert property (p_year_pulse) else $error("year pulse too long");

    property p_single_once;
        year_pulse && single_mode && s.year_done && !s.w_pend |=> !$rose(year_out);
    endproperty
    a_single_once: assert property (p_single_once) else $error("single pulse repeated");

    property p_week_hold;
        !eval_strobe |=> $stable(week_out);
    endproperty
    a_week_hold: assert property (p_week_hold) else $error("week output moved off strobe");

    property p_unset_quiet;
        s.cam[0][calendar_pkg::CAM_ON_UNSET] && s.cam[1][calendar_pkg::CAM_ON_UNSET] &&
        s.cam[2][calendar_pkg::CAM_ON_UNSET] |-> !any_on;
    endproperty
    a_unset_quiet: assert property (p_unset_quiet) else $error("unset on time matched");

    property p_mask_quiet;
        !s.cam[0][calendar_pkg::CAM_MASK_LSB + int'(tod_weekday)] |->
            !on_hits[0] && !off_hits[0];
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("cam acted on masked day");

    property p_cam_legal;
        calendar_pkg::cam_ok(s.cam[0]) && calendar_pkg::cam_ok(s.cam[1]) &&
        calendar_pkg::cam_ok(s.cam[2]);
    endproperty
    a_cam_legal: assert property (p_cam_legal) else $error("cam time out of range");

    property p_year_hold;
        !eval_strobe |=> $stable(year_out);
    endproperty
    a_year_hold: assert property (p_year_hold) else $error("year output moved off strobe");

    property p_year_set;
        !year_pulse && day_tick && year_set |=> year_out;
    endproperty
    a_year_set: assert property (p_year_set) else $error("year on date missed");

    property p_year_clr;
        !year_pulse && day_tick && year_clr && !year_set |=> !year_out;
    endproperty
    a_year_clr: assert property (p_year_clr) else $error("year off date missed");

    property p_year_fire;
        year_pulse && day_tick && year_set && !(single_mode && s.year_done) |=> year_out;
    endproperty
    a_year_fire: assert property (p_year_fire) else $error("year pulse missed");

    property p_done_set;
        year_pulse && single_mode && day_tick && year_set && !s.w_pend |=> s.year_done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("single pulse not recorded");

    // last year of a wrapping yearly span: the on date must not start it again
    sequence s_last_wrap_day;
        day_tick && s.ctrl[calendar_pkg::CTRL_YEARLY] && !s.ctrl[calendar_pkg::CTRL_MONTHLY] &&
        tod_year == s.off_date[calendar_pkg::DATE_YEAR_LSB +: 7];
    endsequence

    sequence s_on_day_wraps;
        {tod_month, tod_day} == {s.on_date[calendar_pkg::DATE_MONTH_LSB +: 4],
                                 s.on_date[calendar_pkg::DATE_DAY_LSB +: 5]} &&
        {s.off_date[calendar_pkg::DATE_MONTH_LSB +: 4],
         s.off_date[calendar_pkg::DATE_DAY_LSB +: 5]} < {tod_month, tod_day};
    endsequence

    property p_wrap_last;
        !year_pulse && !year_out ##0 s_last_wrap_day ##0 s_on_day_wraps |=> !year_out;
    endproperty
    a_wrap_last: assert property (p_wrap_last) else $error("span restarted after last year");
endmodule : calendar_time_switch

/* File: rtl/calendar_pkg.sv */
/*
 * constants, register map and check functions for the calendar time switch.
 * assumes a 32-bit AHB-Lite register bus and a time source giving year 0..99
 * (2000..2099), month 1..12, day 1..31, weekday 0..6 (monday = 0), hour, minute.
 */
package calendar_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CAM0 = 8'h04;
    localparam logic [7:0] ADDR_CAM1 = 8'h08;
    localparam logic [7:0] ADDR_CAM2 = 8'h0C;
    localparam logic [7:0] ADDR_ON_DATE = 8'h10;
    localparam logic [7:0] ADDR_OFF_DATE = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam int NUM_CAMS = 3;
    // control bits
    localparam int CTRL_W = 4;
    localparam int CTRL_WEEK_PULSE = 0;
    localparam int CTRL_MONTHLY = 1;
    localparam int CTRL_YEARLY = 2;
    localparam int CTRL_YEAR_PULSE = 3;
    // cam word layout
    localparam int CAM_MASK_LSB = 0;
    localparam int CAM_ON_HR_LSB = 8;
    localparam int CAM_ON_MIN_LSB = 13;
    localparam int CAM_ON_UNSET = 19;
    localparam int CAM_OFF_HR_LSB = 20;
    localparam int CAM_OFF_MIN_LSB = 25;
    localparam int CAM_OFF_UNSET = 31;
    // date word layout: year above month above day
    localparam int DATE_DAY_LSB = 0;
    localparam int DATE_MONTH_LSB = 8;
    localparam int DATE_YEAR_LSB = 16;
    // status bits
    localparam int STAT_WEEK = 0;
    localparam int STAT_YEAR = 1;
    localparam int STAT_DONE = 2;
    // reset values and limits
    localparam logic [31:0] CAM_RESET = 32'h8008_0000;
    localparam logic [31:0] DATE_RESET = 32'h0000_0101;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [4:0] DAY_MAX = 5'h1F;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [5:0] MINUTE_MAX = 6'h3B;
    localparam logic [4:0] MIDNIGHT_HR = 5'h00;
    localparam logic [5:0] MIDNIGHT_MIN = 6'h00;

    function automatic logic cam_ok(input logic [31:0] v);
        logic on_ok;
        logic off_ok;
        on_ok = v[CAM_ON_UNSET] || (v[CAM_ON_HR_LSB +: 5] <= HOUR_MAX &&
                v[CAM_ON_MIN_LSB +: 6] <= MINUTE_MAX);
        off_ok = v[CAM_OFF_UNSET] || (v[CAM_OFF_HR_LSB +: 5] <= HOUR_MAX &&
                 v[CAM_OFF_MIN_LSB +: 6] <= MINUTE_MAX);
        return on_ok && off_ok;
    endfunction : cam_ok

    function automatic logic date_ok(input logic [31:0] v);
        return v[DATE_YEAR_LSB +: 7] <= YEAR_MAX && v[DATE_MONTH_LSB +: 4] != 4'h0 &&
               v[DATE_MONTH_LSB +: 4] <= MONTH_MAX && v[DATE_DAY_LSB +: 5] != 5'h00;
    endfunction : date_ok
endpackage : calendar_pkg

/* File: rtl/cam_match.sv */
/*
 * one weekly cam: compares its day mask and on/off times with the current time.
 * assumes weekday 0..6 and a cam word in the package layout.
 */
`timescale 1ns/100ps
module cam_match (
    input wire logic [31:0] cam,
    input wire logic [2:0] weekday,
    input wire logic [4:0] hour,
    input wire logic [5:0] minute,
    output logic on_hit,
    output logic off_hit
);
    logic [6:0] mask;
    logic day_sel;
    assign mask = cam[calendar_pkg::CAM_MASK_LSB +: 7];
    assign day_sel = mask[weekday];
    assign on_hit = day_sel && !cam[calendar_pkg::CAM_ON_UNSET] &&
                    cam[calendar_pkg::CAM_ON_HR_LSB +: 5] == hour &&
                    cam[calendar_pkg::CAM_ON_MIN_LSB +: 6] == minute;
    assign off_hit = day_sel && !cam[calendar_pkg::CAM_OFF_UNSET] &&
                     cam[calendar_pkg::CAM_OFF_HR_LSB +: 5] == hour &&
                     cam[calendar_pkg::CAM_OFF_MIN_LSB +: 6] == minute;
endmodule : cam_match

/* File: rtl/year_match.sv */
/*
 * yearly date switch compare: set and clear conditions for the current date.
 * assumes dates in the package layout; the caller applies them only at midnight.
 */
`timescale 1ns/100ps
module year_match (
    input wire logic monthly,
    input wire logic yearly,
    input wire logic [31:0] on_date,
    input wire logic [31:0] off_date,
    input wire logic [6:0] year,
    input wire logic [3:0] month,
    input wire logic [4:0] day,
    output logic set_hit,
    output logic clr_hit
);
    logic [15:0] cur;
    logic [15:0] on_d;
    logic [15:0] off_d;
    logic in_years;
    logic wrap;
    // year, month, day packed in that order so one compare orders dates
    assign cur = {year, month, day};
    assign on_d = {on_date[calendar_pkg::DATE_YEAR_LSB +: 7],
                   on_date[calendar_pkg::DATE_MONTH_LSB +: 4],
                   on_date[calendar_pkg::DATE_DAY_LSB +: 5]};
    assign off_d = {off_date[calendar_pkg::DATE_YEAR_LSB +: 7],
                    off_date[calendar_pkg::DATE_MONTH_LSB +: 4],
                    off_date[calendar_pkg::DATE_DAY_LSB +: 5]};
    assign in_years = year >= on_d[15:9] && year <= off_d[15:9];
    assign wrap = off_d[8:0] < on_d[8:0];

    always_comb begin
        if (monthly) begin
            set_hit = in_years && day == on_d[4:0];
            clr_hit = in_years && day == off_d[4:0];
        end else if (yearly) begin
            // a wrapping span that ends in the last year does not start again
            set_hit = in_years && cur[8:0] == on_d[8:0] &&
                      !(wrap && year == off_d[15:9]);
            clr_hit = in_years && cur[8:0] == off_d[8:0];
        end else begin
            set_hit = cur == on_d;
            clr_hit = cur == off_d;
        end
    end
endmodule : year_match

/* File: sim/tod_source.sv */
/*
 * time source model: presents a calendar time with a one-cycle strobe.
 * assumes the bench asks for each evaluation by raising go for one cycle.
 */
`timescale 1ns/100ps
module tod_source (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire logic [29:0] tm,
    output logic eval_strobe,
    output logic [6:0] tod_year,
    output logic [3:0] tod_month,
    output logic [4:0] tod_day,
    output logic [2:0] tod_weekday,
    output logic [4:0] tod_hour,
    output logic [5:0] tod_minute
);
    // time fields change only together with the strobe, then hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eval_strobe <= 1'b0;
            {tod_year, tod_month, tod_day, tod_weekday, tod_hour, tod_minute} <= 30'h0000_0000;
        end else begin
            eval_strobe <= go;
            if (go) begin
                {tod_year, tod_month, tod_day, tod_weekday, tod_hour, tod_minute} <= tm;
            end
        end
    end
endmodule : tod_source

/* File: sim/calendar_time_switch_tb.sv */
/*
 * bench for the calendar time switch: registers over AHB-Lite, weekly
 * cams and yearly date modes driven through the time source model.
 * assumes the package register map.
 */
`timescale 1ns/100ps
module calendar_time_switch_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic go = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [29:0] tm = 30'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, eval_strobe, week_out, year_out;
    logic [6:0] tod_year;
    logic [3:0] tod_month;
    logic [4:0] tod_day, tod_hour;
    logic [2:0] tod_weekday;
    logic [5:0] tod_minute;
    int num_errors = 0;
    int compares = 0;
    int ty_wd = 0;

    calendar_time_switch uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eval_strobe(eval_strobe),
        .tod_year(tod_year), .tod_month(tod_month), .tod_day(tod_day),
        .tod_weekday(tod_weekday), .tod_hour(tod_hour), .tod_minute(tod_minute),
        .week_out(week_out), .year_out(year_out)
    );
    tod_source src (
        .hclk(hclk), .hresetn(hresetn), .go(go), .tm(tm), .eval_strobe(eval_strobe),
        .tod_year(tod_year), .tod_month(tod_month), .tod_day(tod_day),
        .tod_weekday(tod_weekday), .tod_hour(tod_hour), .tod_minute(tod_minute)
    );

    initial begin
        forever #50 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        check(r, e);
        check({31'h0, hresp}, 32'h0000_0000);
        check({31'h0, hreadyout}, 32'h0000_0001);
    endtask : rd

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    // one evaluation at the given time; checks the week or year output after it
    task automatic tick(input int y, m, d, wd, h, mi, input logic yr, input logic e);
        @(posedge hclk);
        go <= 1'b1;
        tm <= {7'(y), 4'(m), 5'(d), 3'(wd), 5'(h), 6'(mi)};
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        #1;
        check({31'h0, yr ? year_out : week_out}, {31'h0, e});
    endtask : tick

    task automatic tw(input int wd, h, mi, input logic e);
        tick(8, 1, 2, wd, h, mi, 1'b0, e);
    endtask : tw

    task automatic ty(input int y, m, d, input logic e);
        // a new weekday each call keeps successive midnights distinct minutes
        ty_wd = (ty_wd + 1) % 7;
        tick(y, m, d, ty_wd, 0, 0, 1'b1, e);
    endtask : ty

    function automatic logic [31:0] cam(int mask, int onh, int onm, int offh, int offm);
        return {1'b0, 6'(offm), 5'(offh), 1'b0, 6'(onm), 5'(onh), 1'b0, 7'(mask)};
    endfunction : cam

    function automatic logic [31:0] date(int y, int m, int d);
        return {9'h000, 7'(y), 4'h0, 4'(m), 3'h0, 5'(d)};
    endfunction : date

    task automatic setup(input int c, input logic [31:0] on = 32'h0000_0101,
                         input logic [31:0] off = 32'h0000_0101);
        do_reset();
        wr(calendar_pkg::ADDR_CTRL, 32'(c));
        wr(calendar_pkg::ADDR_ON_DATE, on);
        wr(calendar_pkg::ADDR_OFF_DATE, off);
    endtask : setup

    task automatic t_regs();
        rd(calendar_pkg::ADDR_CAM1, calendar_pkg::CAM_RESET);
        rd(calendar_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0000_0000);
        wr(calendar_pkg::ADDR_CAM2, cam(127, 24, 0, 1, 0));
        rd(calendar_pkg::ADDR_CAM2, calendar_pkg::CAM_RESET);
        wr(calendar_pkg::ADDR_ON_DATE, date(100, 1, 1));
        rd(calendar_pkg::ADDR_ON_DATE, calendar_pkg::DATE_RESET);
        wr(calendar_pkg::ADDR_ON_DATE, date(99, 12, 31));
        rd(calendar_pkg::ADDR_ON_DATE, date(99, 12, 31));
    endtask : t_regs

    task automatic t_overlap();
        setup(0);
        wr(calendar_pkg::ADDR_CAM0, cam(127, 1, 0, 2, 0));
        wr(calendar_pkg::ADDR_CAM1, cam(127, 1, 10, 1, 50));
        wr(calendar_pkg::ADDR_CAM2, cam(127, 1, 20, 1, 40));
        tw(0, 1, 0, 1);
        tw(0, 1, 30, 1);
        tw(0, 1, 40, 0);
        tw(0, 1, 50, 0);
        tw(0, 2, 0, 0);
    endtask : t_overlap

    task automatic t_mask();
        setup(0);
        wr(calendar_pkg::ADDR_CAM0, cam(127, 0, 0, 3, 20) | 32'h0008_0000);
        wr(calendar_pkg::ADDR_CAM1, cam(2, 3, 10, 0, 0) | 32'h8000_0000);
        rd(calendar_pkg::ADDR_CAM1, cam(2, 3, 10, 0, 0) | 32'h8000_0000);
        tw(0, 0, 0, 0);
        tw(0, 3, 10, 0);
        tw(1, 3, 10, 1);
        tw(1, 4, 15, 1);
        rd(calendar_pkg::ADDR_STATUS, 32'h0000_0001);
        tw(1, 23, 59, 1);
        tw(2, 3, 20, 0);
    endtask : t_mask

    task automatic t_wpulse();
        setup(1);
        wr(calendar_pkg::ADDR_CAM2, cam(127, 5, 0, 6, 0));
        tw(3, 5, 0, 1);
        tw(3, 5, 0, 0);
        tw(3, 5, 1, 0);
        tw(3, 6, 0, 0);
    endtask : t_wpulse

    task automatic t_years();
        setup(4, date(8, 12, 15), date(10, 1, 7));
        ty(7, 12, 15, 0);
        ty(8, 12, 15, 1);
        ty(9, 1, 7, 0);
        ty(9, 12, 15, 1);
        ty(10, 1, 7, 0);
        ty(10, 12, 15, 0);
        setup(2, date(8, 1, 1), date(10, 1, 5));
        tick(9, 4, 1, 0, 7, 0, 1'b1, 1'b0);
        ty(9, 5, 1, 1);
        tick(9, 5, 5, 0, 9, 0, 1'b1, 1'b1);
        ty(9, 6, 5, 0);
        ty(11, 1, 1, 0);
    endtask : t_years

    task automatic t_once();
        setup(8, date(8, 3, 15));
        ty(8, 3, 15, 1);
        tick(8, 3, 15, 0, 0, 1, 1'b1, 1'b0);
        ty(8, 3, 15, 0);
        ty(9, 3, 15, 0);
        rd(calendar_pkg::ADDR_STATUS, 32'h0000_0004);
        setup(12, date(8, 3, 15), date(10, 1, 1));
        ty(9, 3, 15, 1);
        ty(9, 3, 16, 0);
        setup(0, date(8, 6, 1), date(10, 8, 31));
        ty(8, 6, 1, 1);
        ty(9, 8, 31, 1);
        ty(10, 8, 31, 0);
    endtask : t_once

    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        do_reset();
        t_regs();
        t_overlap();
        t_mask();
        t_wpulse();
        t_years();
        t_once();
        finish_test();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #5_000_000;
        num_errors++;
        finish_test();
    end
endmodule : calendar_time_switch_tb
